// [src/sscr_pkg.sv]
// package: constants and carrier types for the serial switch command registers
package sscr_pkg;

  localparam int WORD_BITS = 16;
  localparam int DATA_BITS = 9;
  localparam int NUM_CH    = 4;

  // command field positions
  localparam int POS_WDOG  = 15;
  localparam int POS_CHHI  = 14;
  localparam int POS_CHLO  = 13;
  localparam int POS_REGHI = 12;
  localparam int POS_REGLO = 10;
  localparam int POS_SPARE = 9;
  localparam int POS_SEL_W = 5;

  // register select codes on bits 12..10
  localparam logic [2:0] REG_STATUS  = 3'h0;
  localparam logic [2:0] REG_DUTY_ON = 3'h1;
  localparam logic [2:0] REG_SWITCH  = 3'h2;
  localparam logic [2:0] REG_FAULT   = 3'h3;
  localparam logic [2:0] REG_OVERCUR = 3'h4;
  localparam logic [2:0] REG_GLOBAL  = 3'h5;
  localparam logic [2:0] REG_CALIB   = 3'h7;
  localparam logic [1:0] CH_GLOBAL   = 2'h0;

  localparam logic [8:0] REG_RESET   = 9'h000;

  // global configuration bit positions
  localparam int GB_SUPPLY_RST_EN = 8;
  localparam int GB_TEMP_EN       = 5;
  localparam int GB_CUR_EN        = 4;
  localparam int GB_CH_HI         = 3;
  localparam int GB_CH_LO         = 2;
  // fault configuration bit positions
  localparam int FB_GAIN          = 0;
  // duty register on bit
  localparam int DB_ON            = 7;

  // status readback select codes
  localparam logic [4:0] SEL_STATUS  = 5'h00;
  localparam logic [4:0] SEL_DUTY    = 5'h01;
  localparam logic [4:0] SEL_SWITCH  = 5'h02;
  localparam logic [4:0] SEL_FAULT   = 5'h03;
  localparam logic [4:0] SEL_OVERCUR = 5'h04;
  localparam logic [4:0] SEL_GLOBAL  = 5'h05;
  localparam logic [4:0] SEL_CALIB   = 5'h07;

  // sense routing choices
  typedef enum logic [1:0] {SENSE_OFF, SENSE_TEMP, SENSE_CURRENT} sscr_sense_t;

  typedef struct packed {
    logic       wdog;
    logic [1:0] chan;
    logic [2:0] regSel;
    logic       spare;
    logic [8:0] data;
  } sscr_cmd_t;

  typedef struct packed {
    sscr_sense_t mode;
    logic [1:0]  chan;
    logic        highGain;
  } sscr_sense_route_t;

endpackage

// [src/sscr_top.sv]
// serial switch command register bank, link side and system side
// ---------------------------------------------------------------
// ---------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none

module sscr_top
  import sscr_pkg::*;
(
  input  wire logic                       clk_sys,
  input  wire logic                       rst,
  input  wire logic                       sclk,
  input  wire logic                       csN,
  input  wire logic                       serialIn,
  input  wire logic                       logicSupplyFail,
  input  wire logic                       porBothLow,
  input  wire logic                       batteryLow,
  input  wire logic                       overtempWarn,
  input  wire logic                       failSafeMode,
  input  wire logic                       clampActive,
  input  wire logic [NUM_CH-1:0]          directIn,
  output logic      [NUM_CH-1:0]          switch_outputs,
  output sscr_pkg::sscr_sense_route_t     analog_sense_pin,
  output logic                            overtemp_prewarning_flag,
  output logic                            undervoltage_flag,
  output logic      [WORD_BITS-1:0]       readbackWord,
  output logic                            watchdog_toggle_bit,
  output logic      [DATA_BITS-1:0]       global_config
);
  import sscr_pkg::*;

  // ---------------------------------------------------------------
  // link domain: shift on sclk, frame ends on csN rise
  // ---------------------------------------------------------------
  logic [WORD_BITS-1:0] shiftQ;
  logic [3:0]           bitCntQ;
  logic                 wordSeenQ;

  // msb arrives first, so shift left
  always_ff @(posedge sclk or posedge csN) begin
    if (csN) begin
      shiftQ    <= '0;
      bitCntQ   <= 4'h0;
      wordSeenQ <= 1'b0;
    end else begin
      shiftQ    <= {shiftQ[WORD_BITS-2:0], serialIn};
      bitCntQ   <= bitCntQ + 4'h1; // wraps every sixteen bits
      wordSeenQ <= 1'b1;
    end
  end

  // capture at csN rise: last word of frame wins, daisy-chain words pass
  logic [WORD_BITS-1:0] frameWordQ;
  logic                 frameOkQ;
  logic                 frameTogQ;
  always_ff @(posedge csN or posedge rst) begin
    if (rst) begin
      frameWordQ <= '0;
      frameOkQ   <= 1'b0;
      frameTogQ  <= 1'b0;
    end else begin
      frameWordQ <= shiftQ;
      frameOkQ   <= wordSeenQ && (bitCntQ == 4'h0); // whole multiples only
      frameTogQ  <= ~frameTogQ;
    end
  end

  // ---------------------------------------------------------------
  // crossing: toggle through three flops, word is stable meanwhile
  // ---------------------------------------------------------------
  logic [2:0] togSyncQ;
  logic       togSeenQ;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      togSyncQ <= 3'h0;
      togSeenQ <= 1'b0;
    end else begin
      togSyncQ <= {togSyncQ[1:0], frameTogQ};
      if (togSyncQ[1] == togSyncQ[2]) begin
        togSeenQ <= togSyncQ[2];
      end
    end
  end
  logic frameEvent;
  assign frameEvent = (togSyncQ[1] == togSyncQ[2]) && (togSyncQ[2] != togSeenQ);

  sscr_cmd_t cmd;
  assign cmd = sscr_cmd_t'(frameWordQ);
  logic cmdValid;
  assign cmdValid = frameEvent && frameOkQ;

  // ---------------------------------------------------------------
  // supply and status inputs: three-flop filters
  // ---------------------------------------------------------------
  logic [2:0] vddSyncQ, porSyncQ, batSyncQ, otwSyncQ, fsSyncQ, clampSyncQ;
  logic       vddFailQ, porLowQ, batLowQ, otwQ, fsQ, clampQ;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      vddSyncQ <= 3'h0; porSyncQ <= 3'h0; batSyncQ <= 3'h0;
      otwSyncQ <= 3'h0; fsSyncQ <= 3'h0; clampSyncQ <= 3'h0;
      vddFailQ <= 1'b0; porLowQ <= 1'b0; batLowQ <= 1'b0;
      otwQ <= 1'b0; fsQ <= 1'b0; clampQ <= 1'b0;
    end else begin
      vddSyncQ   <= {vddSyncQ[1:0], logicSupplyFail};
      porSyncQ   <= {porSyncQ[1:0], porBothLow};
      batSyncQ   <= {batSyncQ[1:0], batteryLow};
      otwSyncQ   <= {otwSyncQ[1:0], overtempWarn};
      fsSyncQ    <= {fsSyncQ[1:0], failSafeMode};
      clampSyncQ <= {clampSyncQ[1:0], clampActive};
      if (vddSyncQ[1] == vddSyncQ[2])     vddFailQ <= vddSyncQ[2];
      if (porSyncQ[1] == porSyncQ[2])     porLowQ  <= porSyncQ[2];
      if (batSyncQ[1] == batSyncQ[2])     batLowQ  <= batSyncQ[2];
      if (otwSyncQ[1] == otwSyncQ[2])     otwQ     <= otwSyncQ[2];
      if (fsSyncQ[1] == fsSyncQ[2])       fsQ      <= fsSyncQ[2];
      if (clampSyncQ[1] == clampSyncQ[2]) clampQ   <= clampSyncQ[2];
    end
  end

  // ---------------------------------------------------------------
  // register file
  // ---------------------------------------------------------------
  logic [DATA_BITS-1:0] statSelQ;
  logic [DATA_BITS-1:0] dutyQ  [NUM_CH];
  logic [DATA_BITS-1:0] swCfgQ [NUM_CH];
  logic [DATA_BITS-1:0] fltCfgQ[NUM_CH];
  logic [DATA_BITS-1:0] ocCfgQ [NUM_CH];
  logic [DATA_BITS-1:0] globQ;
  logic [DATA_BITS-1:0] calQ;

  // battery loss alone wipes nothing, so configuration is kept
  logic wipeRegs;
  assign wipeRegs = porLowQ || (vddFailQ && globQ[GB_SUPPLY_RST_EN]);

  function automatic logic hitReg(input sscr_cmd_t c, input logic [2:0] code);
    hitReg = (c.regSel == code);
  endfunction

  // only channel 00 is legal for the global and calibration words
  function automatic logic hitGlobalReg(input sscr_cmd_t c, input logic [2:0] code);
    hitGlobalReg = (c.regSel == code) && (c.chan == CH_GLOBAL);
  endfunction

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      statSelQ <= REG_RESET;
    end else if (wipeRegs) begin
      statSelQ <= REG_RESET;
    end else if (cmdValid && hitReg(cmd, REG_STATUS)) begin
      statSelQ <= cmd.data;
    end
  end

  // per-channel banks; channel code indexes directly
  for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_chan
    logic chHit;
    assign chHit = cmdValid && (cmd.chan == 2'(ch));
    always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
        dutyQ[ch]   <= REG_RESET;
        swCfgQ[ch]  <= REG_RESET;
        fltCfgQ[ch] <= REG_RESET;
        ocCfgQ[ch]  <= REG_RESET;
      end else if (wipeRegs) begin
        dutyQ[ch]   <= REG_RESET;
        swCfgQ[ch]  <= REG_RESET;
        fltCfgQ[ch] <= REG_RESET;
        ocCfgQ[ch]  <= REG_RESET;
      end else if (chHit) begin
        if (hitReg(cmd, REG_DUTY_ON)) begin
          dutyQ[ch] <= cmd.data;
        end else if (hitReg(cmd, REG_SWITCH)) begin
          swCfgQ[ch] <= cmd.data;
        end else if (hitReg(cmd, REG_FAULT)) begin
          fltCfgQ[ch] <= cmd.data;
        end else if (hitReg(cmd, REG_OVERCUR)) begin
          ocCfgQ[ch] <= cmd.data;
        end
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      globQ <= REG_RESET;
      calQ  <= REG_RESET;
    end else if (wipeRegs) begin
      globQ <= REG_RESET;
      calQ  <= REG_RESET;
    end else if (cmdValid && hitGlobalReg(cmd, REG_GLOBAL)) begin
      globQ <= cmd.data;
    end else if (cmdValid && hitGlobalReg(cmd, REG_CALIB)) begin
      calQ <= cmd.data;
    end
  end

  // ---------------------------------------------------------------
  // flags
  // ---------------------------------------------------------------
  logic readCmd;
  assign readCmd = cmdValid && hitReg(cmd, REG_STATUS);

  // a new warning in the read cycle wins over the clear
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      overtemp_prewarning_flag <= 1'b0;
    end else if (porLowQ || vddFailQ) begin
      overtemp_prewarning_flag <= 1'b0;
    end else if (otwQ && !fsQ) begin
      overtemp_prewarning_flag <= 1'b1;
    end else if (readCmd) begin
      overtemp_prewarning_flag <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      undervoltage_flag <= 1'b0;
    end else if (porLowQ || vddFailQ) begin
      undervoltage_flag <= 1'b0;
    end else if (batLowQ) begin
      undervoltage_flag <= 1'b1;
    end else if (readCmd) begin
      undervoltage_flag <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // readback word
  // ---------------------------------------------------------------
  logic [WORD_BITS-1:0] rdNext;
  always_comb begin
    rdNext = '0;
    case (statSelQ[POS_SEL_W-1:0])
      SEL_STATUS:  rdNext = {13'h0000, fsQ, undervoltage_flag, overtemp_prewarning_flag};
      SEL_DUTY:    rdNext = {7'h00, dutyQ[0]};
      SEL_SWITCH:  rdNext = {7'h00, swCfgQ[0]};
      SEL_FAULT:   rdNext = {7'h00, fltCfgQ[0]};
      SEL_OVERCUR: rdNext = {7'h00, ocCfgQ[0]};
      SEL_GLOBAL:  rdNext = {7'h00, globQ};
      SEL_CALIB:   rdNext = {7'h00, calQ};
      default:     rdNext = '0;
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      readbackWord        <= '0;
      watchdog_toggle_bit <= 1'b0;
      global_config       <= REG_RESET;
    end else begin
      readbackWord  <= rdNext;
      global_config <= globQ;
      if (cmdValid) begin
        watchdog_toggle_bit <= cmd.wdog; // host toggles it
      end
    end
  end

  // ---------------------------------------------------------------
  // outputs and sense routing
  // ---------------------------------------------------------------
  // direct pins are asynchronous too, so they get the same agreeing filter
  logic [NUM_CH-1:0] dirS0Q;
  logic [NUM_CH-1:0] dirS1Q;
  logic [NUM_CH-1:0] dirS2Q;
  logic [NUM_CH-1:0] dirQ;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      dirS0Q <= '0;
      dirS1Q <= '0;
      dirS2Q <= '0;
      dirQ   <= '0;
    end else begin
      dirS0Q <= directIn;
      dirS1Q <= dirS0Q;
      dirS2Q <= dirS1Q;
      dirQ   <= (dirS2Q & ~(dirS1Q ^ dirS2Q)) | (dirQ & (dirS1Q ^ dirS2Q));
    end
  end

  logic [NUM_CH-1:0] onCmd;
  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      // after a power-on wipe, or a supply-loss wipe with the enable bit set, the zeroed registers leave direct pins in charge
      onCmd[i] = dutyQ[i][DB_ON] | dirQ[i];
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      switch_outputs <= '0;
    end else if (clampQ) begin
      switch_outputs <= '1;
    end else begin
      switch_outputs <= onCmd;
    end
  end

  sscr_sense_route_t senseNext;
  logic [1:0]        senseCh;
  always_comb begin
    senseCh            = {globQ[GB_CH_HI], globQ[GB_CH_LO]};
    senseNext.chan     = senseCh;
    senseNext.highGain = fltCfgQ[senseCh][FB_GAIN];
    senseNext.mode     = SENSE_OFF;
    if (globQ[GB_TEMP_EN]) begin
      senseNext.mode = SENSE_TEMP;
    end else if (globQ[GB_CUR_EN] && !fsQ && onCmd[senseCh]) begin
      senseNext.mode = SENSE_CURRENT;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      analog_sense_pin <= '{mode: SENSE_OFF, chan: 2'h0, highGain: 1'b0};
    end else begin
      analog_sense_pin <= senseNext;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  chk_clamp_forces_on: assert property (@(posedge clk_sys) disable iff (rst)
    clampQ |=> (switch_outputs == '1))
    else $error("clamp did not force outputs on");

  chk_wipe_clears_global: assert property (@(posedge clk_sys) disable iff (rst)
    porLowQ |=> (globQ == REG_RESET))
    else $error("global config survived power-on reset");

  chk_vdd_wipe: assert property (@(posedge clk_sys) disable iff (rst)
    (vddFailQ && globQ[GB_SUPPLY_RST_EN]) |=> (statSelQ == REG_RESET))
    else $error("supply-loss wipe missed");

  chk_partial_ignored: assert property (@(posedge clk_sys) disable iff (rst)
    (frameEvent && !frameOkQ && !wipeRegs) |=> $stable(globQ) && $stable(calQ))
    else $error("partial frame changed a register");

  chk_global_write: assert property (@(posedge clk_sys) disable iff (rst)
    (cmdValid && !wipeRegs && cmd.regSel == REG_GLOBAL && cmd.chan == CH_GLOBAL)
      |=> (globQ == $past(cmd.data)))
    else $error("global register not written");

  chk_otw_latch: assert property (@(posedge clk_sys) disable iff (rst)
    (otwQ && !fsQ && !porLowQ && !vddFailQ) |=> overtemp_prewarning_flag)
    else $error("prewarning not latched");

  chk_otw_hold: assert property (@(posedge clk_sys) disable iff (rst)
    (overtemp_prewarning_flag && !readCmd && !porLowQ && !vddFailQ)
      |=> overtemp_prewarning_flag)
    else $error("prewarning dropped without read");

  chk_uv_report: assert property (@(posedge clk_sys) disable iff (rst)
    (batLowQ && !porLowQ && !vddFailQ) |=> undervoltage_flag)
    else $error("undervoltage not reported");

  chk_no_fs_current: assert property (@(posedge clk_sys) disable iff (rst)
    fsQ |=> (analog_sense_pin.mode != SENSE_CURRENT))
    else $error("current feedback in fail-safe");

endmodule

`default_nettype wire

// [bench/sscr_host_model.sv]
// host model: serial bus master that frames commands for the switch register bank
`timescale 1ns/1ps
`default_nettype none

module sscr_host_model (
  output logic sclk,
  output logic csN,
  output logic serialIn
);
  import sscr_pkg::*;

  logic wdogQ;

  initial begin
    sclk     = 1'b0;
    csN      = 1'b1;
    serialIn = 1'b0;
    wdogQ    = 1'b0;
  end

  // -------------------------------------------------------------
  // framing
  // -------------------------------------------------------------
  // sends the low n bits, msb first; the clock stands still low between frames
  task automatic raw(input logic [31:0] bits, input int n);
    #13 csN = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      serialIn = bits[i];
      #40 sclk = 1'b1;
      #40 sclk = 1'b0;
    end
    #40 csN = 1'b1;
    // a released data line must not keep showing the last bit
    serialIn = ~serialIn;
    #200;
  endtask

  task automatic cmd(input logic [1:0] ch, input logic [2:0] rs, input logic [8:0] d);
    sscr_cmd_t w;
    wdogQ = ~wdogQ;
    w = '{wdog: wdogQ, chan: ch, regSel: rs, spare: 1'b0, data: d};
    raw({16'h0000, w}, WORD_BITS);
  endtask

endmodule

`default_nettype wire

// [bench/tb_spi_switch_command_regs.sv]
// testbench: drives the command register bank through its serial port and side inputs
`timescale 1ns/1ps
`default_nettype none

module tb_spi_switch_command_regs;
  import sscr_pkg::*;

  logic              clk_sys = 1'b0;
  logic              rst = 1'b1;
  logic              sclk;
  logic              csN;
  logic              serialIn;
  logic              logicSupplyFail = 1'b0;
  logic              porBothLow = 1'b0;
  logic              batteryLow = 1'b0;
  logic              overtempWarn = 1'b0;
  logic              failSafeMode = 1'b0;
  logic              clampActive = 1'b0;
  logic [3:0]        directIn = 4'h0;
  logic [3:0]        swOut;
  sscr_sense_route_t sensePin;
  logic              otwFlag;
  logic              uvFlag;
  logic [15:0]       readbackWord;
  logic              wdogBit;
  logic [8:0]        globalCfg;
  int                errCount = 0;
  int                comparisons = 0;
  int                cycles = 0;

  always #10 clk_sys = ~clk_sys;

  sscr_host_model host (.sclk(sclk), .csN(csN), .serialIn(serialIn));

  sscr_top uut (
    .clk_sys(clk_sys), .rst(rst), .sclk(sclk), .csN(csN), .serialIn(serialIn),
    .logicSupplyFail(logicSupplyFail), .porBothLow(porBothLow), .batteryLow(batteryLow),
    .overtempWarn(overtempWarn), .failSafeMode(failSafeMode), .clampActive(clampActive),
    .directIn(directIn), .switch_outputs(swOut), .analog_sense_pin(sensePin),
    .overtemp_prewarning_flag(otwFlag), .undervoltage_flag(uvFlag),
    .readbackWord(readbackWord), .watchdog_toggle_bit(wdogBit), .global_config(globalCfg)
  );

  // -------------------------------------------------------------
  // helpers
  // -------------------------------------------------------------
  task automatic stopTest();
    if (errCount == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // generous ceiling: the whole sequence needs about 3200 cycles
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      errCount++;
      $display("BAD %0t timeout", $time);
      stopTest();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
    comparisons++;
    if (got !== exp) begin
      errCount++;
      $display("BAD %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  // fixed wait covers the crossing plus output stage with margin
  task automatic settle();
    repeat (8) @(negedge clk_sys);
  endtask

  task automatic put(input logic [1:0] ch, input logic [2:0] rs, input logic [8:0] d);
    host.cmd(ch, rs, d);
    settle();
  endtask

  task automatic rb(input logic [4:0] sel, input logic [8:0] exp);
    put(2'h0, REG_STATUS, {4'h0, sel});
    chk(readbackWord, {7'h0, exp}, "readback");
  endtask

  function automatic logic [15:0] word(logic wd, logic [2:0] rs, logic [8:0] d);
    return {wd, CH_GLOBAL, rs, 1'b0, d};
  endfunction

  // -------------------------------------------------------------
  // scenarios
  // -------------------------------------------------------------
  task automatic testReset();
    chk({7'h0, globalCfg}, 16'h0000, "global after reset");
    chk({12'h0, swOut}, 16'h0000, "outputs after reset");
    chk({13'h0, otwFlag, uvFlag, wdogBit}, 16'h0000, "flags after reset");
  endtask

  task automatic testChannels();
    logic [3:0] exp;
    exp = 4'h0;
    for (int c = 0; c < NUM_CH; c++) begin
      put(2'(c), REG_DUTY_ON, 9'h080);
      exp[c] = 1'b1;
      chk({12'h0, swOut}, {12'h0, exp}, "channel on");
      chk({15'h0, wdogBit}, {15'h0, host.wdogQ}, "watchdog bit");
    end
    for (int c = NUM_CH - 1; c >= 0; c--) begin
      put(2'(c), REG_DUTY_ON, 9'h000);
      exp[c] = 1'b0;
      chk({12'h0, swOut}, {12'h0, exp}, "channel off");
    end
    @(negedge clk_sys) directIn = 4'h5;
    settle();
    chk({12'h0, swOut}, 16'h0005, "direct pins");
    @(negedge clk_sys) directIn = 4'h0;
    settle();
  endtask

  task automatic testSense();
    put(CH_GLOBAL, REG_GLOBAL, 9'h03c);
    chk({7'h0, globalCfg}, 16'h003c, "global write");
    chk(16'(sensePin.mode), 16'(SENSE_TEMP), "temp routing");
    chk({14'h0, sensePin.chan}, 16'h0003, "sense channel");
    put(CH_GLOBAL, REG_GLOBAL, 9'h01c);
    chk(16'(sensePin.mode), 16'(SENSE_OFF), "current while off");
    put(2'h3, REG_DUTY_ON, 9'h080);
    put(2'h3, REG_FAULT, 9'h001);
    chk(16'(sensePin.mode), 16'(SENSE_CURRENT), "current while on");
    chk({15'h0, sensePin.highGain}, 16'h0001, "gain select");
    @(negedge clk_sys) failSafeMode = 1'b1;
    settle();
    chk(16'(sensePin.mode), 16'(SENSE_OFF), "fail-safe current");
    @(negedge clk_sys) failSafeMode = 1'b0;
    settle();
  endtask

  task automatic testFraming();
    logic [15:0] w;
    w = word(1'b0, REG_GLOBAL, 9'h0aa);
    host.raw({17'h0, w[15:1]}, 15);
    settle();
    chk({7'h0, globalCfg}, 16'h001c, "15-bit frame");
    host.raw({15'h0, w, 1'b1}, 17);
    settle();
    chk({7'h0, globalCfg}, 16'h001c, "17-bit frame");
    host.raw({word(1'b0, REG_GLOBAL, 9'h055), word(1'b1, REG_GLOBAL, 9'h033)}, 32);
    settle();
    chk({7'h0, globalCfg}, 16'h0033, "two-word frame");
    chk({15'h0, wdogBit}, 16'h0001, "last word watchdog");
    put(2'h1, REG_GLOBAL, 9'h1ff);
    put(2'h0, 3'h6, 9'h1ff);
    chk({7'h0, globalCfg}, 16'h0033, "refused global");
    put(2'h0, REG_DUTY_ON, 9'h07f);
    put(2'h0, REG_CALIB, 9'h15b);
    put(2'h0, REG_SWITCH, 9'h018);
    put(2'h0, REG_FAULT, 9'h01e);
    put(2'h0, REG_OVERCUR, 9'h0c5);
    rb(SEL_SWITCH, 9'h018);
    rb(SEL_FAULT, 9'h01e);
    rb(SEL_OVERCUR, 9'h0c5);
    rb(SEL_DUTY, 9'h07f);
    rb(SEL_GLOBAL, 9'h033);
    rb(SEL_CALIB, 9'h15b);
  endtask

  task automatic testPrewarn();
    @(negedge clk_sys) overtempWarn = 1'b1;
    settle();
    @(negedge clk_sys) overtempWarn = 1'b0;
    settle();
    chk({15'h0, otwFlag}, 16'h0001, "prewarning latched");
    put(CH_GLOBAL, REG_GLOBAL, 9'h033);
    chk({15'h0, otwFlag}, 16'h0001, "kept over write");
    rb(SEL_STATUS, 9'h000);
    chk({15'h0, otwFlag}, 16'h0000, "cleared by read");
  endtask

  task automatic testSupply();
    @(negedge clk_sys) batteryLow = 1'b1;
    settle();
    chk({15'h0, uvFlag}, 16'h0001, "undervoltage flag");
    rb(SEL_STATUS, 9'h002);
    chk({15'h0, uvFlag}, 16'h0001, "undervoltage kept while low");
    put(CH_GLOBAL, REG_GLOBAL, 9'h034);
    chk({7'h0, globalCfg}, 16'h0034, "serial kept");
    @(negedge clk_sys) batteryLow = 1'b0;
    logicSupplyFail = 1'b1;
    settle();
    chk({7'h0, globalCfg}, 16'h0034, "no wipe when disabled");
    @(negedge clk_sys) logicSupplyFail = 1'b0;
    settle();
    put(CH_GLOBAL, REG_GLOBAL, 9'h134);
    @(negedge clk_sys) logicSupplyFail = 1'b1;
    settle();
    chk({7'h0, globalCfg}, 16'h0000, "wipe when enabled");
    @(negedge clk_sys) logicSupplyFail = 1'b0;
    settle();
    put(2'h1, REG_DUTY_ON, 9'h080);
    put(CH_GLOBAL, REG_GLOBAL, 9'h00c);
    @(negedge clk_sys) porBothLow = 1'b1;
    settle();
    chk({3'h0, swOut, globalCfg}, 16'h0000, "power-on wipe");
    @(negedge clk_sys) porBothLow = 1'b0;
    settle();
  endtask

  task automatic testClamp();
    @(negedge clk_sys) clampActive = 1'b1;
    settle();
    chk({12'h0, swOut}, 16'h000f, "clamp forces on");
    @(negedge clk_sys) clampActive = 1'b0;
    settle();
    chk({12'h0, swOut}, 16'h0000, "clamp released");
  endtask

  initial begin
    repeat (5) @(negedge clk_sys);
    rst = 1'b0;
    settle();
    testReset();
    testChannels();
    testSense();
    testFraming();
    testPrewarn();
    testSupply();
    testClamp();
    stopTest();
  end

endmodule

`default_nettype wire
